// file: sim/timer_ab_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t mismatch got %h expected %h", $time, g, e); end end
module timer_ab_tb_top;
    import timer_ab_pkg::*;
    logic       i_clock = 1'b0;
    logic       i_rst = 1'b1;
    logic [9:0] i_addr = 10'h000;
    logic [3:0] i_wdata = 4'h0;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_stop_mode = 1'b0;
    logic       i_watch_mode = 1'b0;
    logic       i_subactive = 1'b0;
    logic       i_sub_clock = 1'b0;
    logic       i_crystal_input = 1'b0;
    logic       i_event_input_pin = 1'b1;
    logic [3:0] o_rdata;
    logic       o_timer_a_irq_flag;
    logic       o_timer_b_irq_flag;
    logic       o_timer_output_pin;
    logic       o_timer_output_en;
    int         miscompares = 0;
    int         checks_done = 0;

    timer_ab dut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_stop_mode,
        .i_watch_mode, .i_subactive, .i_sub_clock, .i_crystal_input, .i_event_input_pin,
        .o_rdata, .o_timer_a_irq_flag, .o_timer_b_irq_flag, .o_timer_output_pin,
        .o_timer_output_en);

    // 250 MHz system clock
    initial begin
        forever #2 i_clock = ~i_clock;
    end

    task automatic close_out;
        $display("compares %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one-cycle write strobe; a gap cycle follows so strobes never collide
    task automatic wr(input logic [9:0] a, input logic [3:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rdchk(input logic [9:0] a, input logic [3:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        `CHK(o_rdata, e)
    endtask

    // high digit first, it latches the low digit for the second read
    task automatic count_chk(input logic [7:0] e);
        rdchk(ADDR_TIMER_B_HIGH, e[7:4]);
        rdchk(ADDR_TIMER_B_LOW, e[3:0]);
    endtask

    task automatic load(input logic [7:0] v);
        wr(ADDR_TIMER_B_LOW, v[3:0]);
        wr(ADDR_TIMER_B_HIGH, v[7:4]);
    endtask

    // one falling edge on the event pin, held long enough for the synchroniser
    task automatic ev;
        @(posedge i_clock);
        i_event_input_pin <= 1'b0;
        repeat (4) @(posedge i_clock);
        i_event_input_pin <= 1'b1;
        repeat (6) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic clr_a(input logic [3:0] strobes);
        wr(ADDR_SOFT_CLEAR, strobes);
        wr(ADDR_IRQ_FLAGS, 4'hb);
    endtask

    // watchdog: the crystal run dominates, the whole run is about 37k cycles
    initial begin
        #240000;
        miscompares++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        @(negedge i_clock);
        `CHK(o_timer_output_pin, 1'b0)
        `CHK({o_timer_a_irq_flag, o_timer_b_irq_flag}, 2'b00)
        rdchk(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_NONE});
        rdchk(ADDR_TIMER_A_MODE, 4'h0);
        rdchk(10'h3ff, 4'h0);
        // event source with the pin unassigned keeps timer B frozen for digit tests
        wr(ADDR_TIMER_B_MODE1, {1'b0, EXT_EVENT_SEL});
        wr(ADDR_TIMER_B_HIGH, 4'h3);
        count_chk(8'h30);
        wr(ADDR_TIMER_B_LOW, 4'h5);
        count_chk(8'h30);
        wr(ADDR_TIMER_B_HIGH, 4'ha);
        count_chk(8'ha5);
        ev();
        count_chk(8'ha5);
        wr(ADDR_PORT_FUNC_C, 4'h8);
        load(8'hfe);
        ev();
        count_chk(8'hff);
        ev();
        count_chk(8'h00);
        repeat (20) @(posedge i_clock);
        rdchk(ADDR_IRQ_FLAGS, 4'h1);
        wr(ADDR_IRQ_FLAGS, 4'he);
        @(negedge i_clock);
        `CHK(o_timer_b_irq_flag, 1'b0)
        // back-to-back mode writes: the second lands inside the hold-off and is dropped
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= ADDR_TIMER_B_MODE1;
        i_wdata <= {1'b1, EXT_EVENT_SEL};
        @(posedge i_clock);
        i_wdata <= {1'b0, EXT_EVENT_SEL};
        @(posedge i_clock);
        i_wr <= 1'b0;
        load(8'hff);
        ev();
        count_chk(8'hff);
        `CHK(o_timer_b_irq_flag, 1'b1)
        // reload of ff makes every event an overflow
        wr(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_TOGGLE});
        rdchk(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_TOGGLE});
        `CHK(o_timer_output_en, 1'b1)
        ev();
        `CHK(o_timer_output_pin, 1'b1)
        ev();
        `CHK(o_timer_output_pin, 1'b0)
        wr(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_ONE});
        ev();
        `CHK(o_timer_output_pin, 1'b1)
        wr(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_ZERO});
        ev();
        `CHK(o_timer_output_pin, 1'b0)
        wr(ADDR_TIMER_B_OUTSEL, {2'h0, OUT_NONE});
        @(negedge i_clock);
        `CHK(o_timer_output_en, 1'b0)
        // prescaler S clocks timer B in reload mode: with ff loaded every tick overflows
        wr(ADDR_TIMER_B_MODE1, 4'h8);
        load(8'hff);
        wr(ADDR_IRQ_FLAGS, 4'he);
        repeat (8) @(posedge i_clock);
        `CHK(o_timer_b_irq_flag, 1'b1)
        count_chk(8'hff);
        // timer A on the fastest prescaler S tap: halted in stop, watch and subactive;
        // the crystal keeps toggling, though timer A on a prescaler S tap never sees prescaler W
        @(posedge i_clock);
        for (int k = 0; k < 3; k++) begin
            {i_stop_mode, i_watch_mode, i_subactive} <= 3'b001 << k;
            clr_a(4'h2);
            repeat (150) begin
                repeat (4) @(posedge i_clock);
                i_crystal_input <= ~i_crystal_input;
            end
            `CHK(o_timer_a_irq_flag, 1'b0)
        end
        {i_stop_mode, i_watch_mode, i_subactive} <= 3'b000;
        clr_a(4'h2);
        repeat (600) @(posedge i_clock);
        `CHK(o_timer_a_irq_flag, 1'b1)
        // subactive: timer A on the prescaler S input gets one clock per sub clock rise
        i_subactive <= 1'b1;
        wr(ADDR_TIMER_A_MODE, 4'h7);
        clr_a(4'h2);
        repeat (510) begin
            repeat (4) @(posedge i_clock);
            i_sub_clock <= ~i_sub_clock;
        end
        `CHK(o_timer_a_irq_flag, 1'b0)
        repeat (6) begin
            repeat (4) @(posedge i_clock);
            i_sub_clock <= ~i_sub_clock;
        end
        repeat (10) @(posedge i_clock);
        `CHK(o_timer_a_irq_flag, 1'b1)
        i_subactive <= 1'b0;
        // time base in watch mode: 256 timer clocks need 4096 crystal rises
        wr(ADDR_TIMER_A_MODE, 4'h8);
        i_watch_mode <= 1'b1;
        clr_a(4'h3);
        repeat (8160) begin
            repeat (4) @(posedge i_clock);
            i_crystal_input <= ~i_crystal_input;
        end
        `CHK(o_timer_a_irq_flag, 1'b0)
        repeat (60) begin
            repeat (4) @(posedge i_clock);
            i_crystal_input <= ~i_crystal_input;
        end
        repeat (10) @(posedge i_clock);
        `CHK(o_timer_a_irq_flag, 1'b1)
        close_out();
    end
endmodule

// file: verilog/timer_ab.sv
// Contract
// - prescaler S: 11-bit, reset to zero, stops in reset, stop, watch modes.
// - prescaler S counts system clock, subsystem clock in subactive mode.
// - prescaler W: 5-bit, counts crystal clock over eight, reset to zero.
// - prescaler W software clearable, runs in watch mode, stops in stop mode.
// - timer clocks come from prescaler taps; A may use W, B events; A code 7 without time base uses the prescaler S input.
// - timer A counts up, wraps at ff, sets its flag every 256 clocks.
// - time-base bit selects prescaler W; software clears W and timer A.
// - timer A mode is a 4-bit write-only register.
// - timer B counts up; at ff reloads or wraps to zero.
// - timer B overflow sets flag bit 0 until software clear or reset.
// - event mode counts falling edges of the event pin once assigned.
// - toggle mode inverts the output on each timer B overflow.
// - 0 mode drives output low on overflow; select only when high.
// - 1 mode drives output high on overflow; select only when low.
// - any output mode claims the pin; reset forces output low.
// - mode1 write takes effect two cycles after the previous one.
// - low load digit waits; high digit write loads timer B.
// - reset clears low load digit; high digit undefined.
// - reading high count digit latches low digit for next read.
// - output select is 2-bit read/write, reset zero, zero means none.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module timer_ab
    import timer_ab_pkg::*;
#(
    // tap of prescaler S per 3-bit select code; code 7 is the event input for timer B
    parameter logic [3:0] S_TAP [0:6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'ha},
    parameter logic [2:0] W_TAP [0:7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4}
) (
    input  wire logic       i_clock,        // 250 MHz system clock
    input  wire logic       i_rst,          // mcu reset, sync active high
    input  wire logic [9:0] i_addr,         // digit address
    input  wire logic [3:0] i_wdata,        // write digit
    input  wire logic       i_wr,           // write strobe
    input  wire logic       i_rd,           // read strobe
    input  wire logic       i_stop_mode,    // stop mode level
    input  wire logic       i_watch_mode,   // watch mode level
    input  wire logic       i_subactive,    // subactive mode level
    input  wire logic       i_sub_clock,    // subsystem clock pin
    input  wire logic       i_crystal_input,// 32 kHz crystal pin
    input  wire logic       i_event_input_pin, // event pin, falling edge counts
    output logic [3:0]      o_rdata,        // read digit, cycle after strobe
    output logic            o_timer_a_irq_flag, // timer A request flag
    output logic            o_timer_b_irq_flag, // timer B request flag
    output logic            o_timer_output_pin, // timer B output level
    output logic            o_timer_output_en   // pin given to timer output
);
    // pin synchronisers: 2 flops, then a third for edge detection
    logic [1:0] sub_sync_reg, xtal_sync_reg, evt_sync_reg;
    logic       sub_prev_reg, xtal_prev_reg, evt_prev_reg;
    always_ff @(posedge i_clock) begin
        sub_sync_reg  <= {sub_sync_reg[0], i_sub_clock};
        xtal_sync_reg <= {xtal_sync_reg[0], i_crystal_input};
        evt_sync_reg  <= {evt_sync_reg[0], i_event_input_pin};
        sub_prev_reg  <= sub_sync_reg[1];
        xtal_prev_reg <= xtal_sync_reg[1];
        evt_prev_reg  <= evt_sync_reg[1];
    end
    wire sub_rise  = sub_sync_reg[1] & ~sub_prev_reg;
    wire xtal_rise = xtal_sync_reg[1] & ~xtal_prev_reg;
    wire evt_fall  = ~evt_sync_reg[1] & evt_prev_reg;

    // register state
    logic [3:0] timer_a_mode_reg, timer_b_mode_one_reg, load_low_reg, load_high_reg;
    logic [3:0] port_func_reg, low_latch_reg;
    logic [1:0] out_sel_reg;
    logic [1:0] mode1_gap_reg;
    logic [7:0] timer_a_reg, timer_b_reg;
    logic [PRESC_S_W-1:0] presc_s_reg;
    logic [PRESC_W_W-1:0] presc_w_reg;
    logic [WDIV_W-1:0]    wdiv_reg;

    wire wr_a     = i_wr && i_addr == ADDR_TIMER_A_MODE;
    wire wr_b1    = i_wr && i_addr == ADDR_TIMER_B_MODE1;
    wire wr_low   = i_wr && i_addr == ADDR_TIMER_B_LOW;
    wire wr_high  = i_wr && i_addr == ADDR_TIMER_B_HIGH;
    wire wr_osel  = i_wr && i_addr == ADDR_TIMER_B_OUTSEL;
    wire wr_pfc   = i_wr && i_addr == ADDR_PORT_FUNC_C;
    wire wr_flags = i_wr && i_addr == ADDR_IRQ_FLAGS;
    wire wr_clr   = i_wr && i_addr == ADDR_SOFT_CLEAR;
    wire rd_high  = i_rd && i_addr == ADDR_TIMER_B_HIGH;
    wire clr_watch = wr_clr && i_wdata[CLR_WATCH_BIT];
    wire clr_ta    = wr_clr && i_wdata[CLR_TIMER_A_BIT];

    // prescaler S: source is system clock, or subsystem clock edges in subactive
    wire s_run  = !i_stop_mode && !i_watch_mode;
    wire s_tick = s_run && (!i_subactive || sub_rise);
    always_ff @(posedge i_clock) begin
        if (i_rst)
            presc_s_reg <= '0;
        else if (s_tick)
            presc_s_reg <= presc_s_reg + 1'b1;
    end

    // divide-by-eight of crystal edges feeds prescaler W
    wire w_run = !i_stop_mode;
    wire w_in  = w_run && xtal_rise && (wdiv_reg == '1);
    always_ff @(posedge i_clock) begin
        if (i_rst || clr_watch)
            wdiv_reg <= '0;
        else if (w_run && xtal_rise)
            wdiv_reg <= wdiv_reg + 1'b1;
    end
    always_ff @(posedge i_clock) begin
        if (i_rst || clr_watch)
            presc_w_reg <= '0;
        else if (w_in)
            presc_w_reg <= presc_w_reg + 1'b1;
    end

    // tap enables: a tap pulses when its bit and all lower bits roll over
    logic [PRESC_S_W-1:0] s_pulse;
    logic [PRESC_W_W-1:0] w_pulse;
    genvar g;
    generate
        for (g = 0; g < PRESC_S_W; g++) begin : g_stap
            assign s_pulse[g] = s_tick && (presc_s_reg[g:0] == '1);
        end
        for (g = 0; g < PRESC_W_W; g++) begin : g_wtap
            assign w_pulse[g] = w_in && (presc_w_reg[g:0] == '1);
        end
    endgenerate

    // clock selection through the tap tables
    wire [2:0] a_sel = timer_a_mode_reg[2:0];
    wire [2:0] b_sel = timer_b_mode_one_reg[2:0];
    wire a_clk = timer_a_mode_reg[TIME_BASE_BIT] ? w_pulse[W_TAP[a_sel]]
                 : (a_sel == EXT_EVENT_SEL ? s_tick : s_pulse[S_TAP[a_sel]]);
    wire evt_en = port_func_reg[EVENT_PIN_BIT];
    wire b_clk  = (b_sel == EXT_EVENT_SEL) ? (evt_en && evt_fall)
                  : s_pulse[S_TAP[b_sel]];

    // mode registers; mode1 ignores a write until the gap since the last one expires
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            timer_a_mode_reg <= DIGIT_ZERO;
            port_func_reg    <= DIGIT_ZERO;
            out_sel_reg      <= OUT_NONE;
        end else begin
            if (wr_a)
                timer_a_mode_reg <= i_wdata;
            if (wr_pfc)
                port_func_reg <= i_wdata;
            if (wr_osel)
                out_sel_reg <= i_wdata[1:0];
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            timer_b_mode_one_reg <= DIGIT_ZERO;
            mode1_gap_reg        <= '0;
        end else if (wr_b1 && mode1_gap_reg == '0) begin
            timer_b_mode_one_reg <= i_wdata;
            mode1_gap_reg        <= 2'(MODE1_HOLDOFF - 1);
        end else if (mode1_gap_reg != '0) begin
            mode1_gap_reg <= mode1_gap_reg - 1'b1;
        end
    end

    // load digits: low held until high written (high not reset, undefined)
    always_ff @(posedge i_clock) begin
        if (i_rst)
            load_low_reg <= DIGIT_ZERO;
        else if (wr_low)
            load_low_reg <= i_wdata;
    end
    always_ff @(posedge i_clock) begin
        if (wr_high)
            load_high_reg <= i_wdata;
    end

    // timer A
    wire a_ovf = a_clk && timer_a_reg == COUNT_MAX;
    always_ff @(posedge i_clock) begin
        if (i_rst || clr_ta)
            timer_a_reg <= COUNT_ZERO;
        else if (a_clk)
            timer_a_reg <= timer_a_reg + 1'b1;
    end

    // timer B: a software load wins over a count in the same cycle
    wire b_ovf = b_clk && timer_b_reg == COUNT_MAX;
    always_ff @(posedge i_clock) begin
        if (i_rst)
            timer_b_reg <= COUNT_ZERO;
        else if (wr_high)
            timer_b_reg <= {i_wdata, load_low_reg};
        else if (b_ovf)
            timer_b_reg <= timer_b_mode_one_reg[RELOAD_BIT]
                           ? {load_high_reg, load_low_reg} : COUNT_ZERO;
        else if (b_clk)
            timer_b_reg <= timer_b_reg + 1'b1;
    end

    // interrupt flags: set beats software clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_timer_a_irq_flag <= 1'b0;
            o_timer_b_irq_flag <= 1'b0;
        end else begin
            if (a_ovf)
                o_timer_a_irq_flag <= 1'b1;
            else if (wr_flags && !i_wdata[FLAG_A_BIT])
                o_timer_a_irq_flag <= 1'b0;
            if (b_ovf)
                o_timer_b_irq_flag <= 1'b1;
            else if (wr_flags && !i_wdata[FLAG_B_BIT])
                o_timer_b_irq_flag <= 1'b0;
        end
    end

    // timer output; software keeps 0/1 modes to the opposite level
    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_timer_output_pin <= 1'b0;
        else if (b_ovf) begin
            unique case (out_sel_reg)
                OUT_NONE:   o_timer_output_pin <= o_timer_output_pin;
                OUT_TOGGLE: o_timer_output_pin <= ~o_timer_output_pin;
                OUT_ZERO:   o_timer_output_pin <= 1'b0;
                OUT_ONE:    o_timer_output_pin <= 1'b1;
            endcase
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_timer_output_en <= 1'b0;
        else
            o_timer_output_en <= (wr_osel ? i_wdata[1:0] : out_sel_reg) != OUT_NONE;
    end

    // read path: high digit read snapshots the low digit
    always_ff @(posedge i_clock) begin
        if (i_rst)
            low_latch_reg <= DIGIT_ZERO;
        else if (rd_high)
            low_latch_reg <= timer_b_reg[3:0];
    end
    always_ff @(posedge i_clock) begin
        if (i_rst)
            o_rdata <= DIGIT_ZERO;
        else if (i_rd) begin
            unique case (i_addr)
                ADDR_TIMER_B_HIGH:   o_rdata <= timer_b_reg[7:4];
                ADDR_TIMER_B_LOW:    o_rdata <= low_latch_reg;
                ADDR_TIMER_B_OUTSEL: o_rdata <= {2'b00, out_sel_reg};
                ADDR_IRQ_FLAGS:      o_rdata <= {1'b0, o_timer_a_irq_flag, 1'b0,
                                                 o_timer_b_irq_flag};
                default:             o_rdata <= DIGIT_ZERO; // write-only and unmapped
            endcase
        end else
            o_rdata <= DIGIT_ZERO;
    end

    // checks
    property p_s_reset;
        @(posedge i_clock) i_rst |=> presc_s_reg == '0;
    endproperty
    a_s_reset: assert property (p_s_reset) else $error("prescaler S not cleared");
    property p_s_hold;
        @(posedge i_clock) disable iff (i_rst) i_watch_mode |=> $stable(presc_s_reg);
    endproperty
    a_s_hold: assert property (p_s_hold) else $error("prescaler S ran in watch");
    property p_w_clear;
        @(posedge i_clock) disable iff (i_rst) clr_watch |=> presc_w_reg == '0;
    endproperty
    a_w_clear: assert property (p_w_clear) else $error("prescaler W not cleared");
    property p_a_wrap;
        @(posedge i_clock) disable iff (i_rst) a_ovf && !clr_ta
            |=> timer_a_reg == COUNT_ZERO && o_timer_a_irq_flag;
    endproperty
    a_a_wrap: assert property (p_a_wrap) else $error("timer A wrap wrong");
    property p_b_ovf;
        @(posedge i_clock) disable iff (i_rst) b_ovf && !wr_high
            |=> o_timer_b_irq_flag && timer_b_reg ==
                ($past(timer_b_mode_one_reg[RELOAD_BIT]) ? $past({load_high_reg, load_low_reg})
                 : COUNT_ZERO);
    endproperty
    a_b_ovf: assert property (p_b_ovf) else $error("timer B overflow wrong");
    property p_toggle;
        @(posedge i_clock) disable iff (i_rst) b_ovf && out_sel_reg == OUT_TOGGLE
            |=> o_timer_output_pin != $past(o_timer_output_pin);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");
    property p_load;
        @(posedge i_clock) disable iff (i_rst) wr_high
            |=> timer_b_reg == {$past(i_wdata), $past(load_low_reg)};
    endproperty
    a_load: assert property (p_load) else $error("timer B load wrong");
    property p_latch;
        @(posedge i_clock) disable iff (i_rst) rd_high ##1 (i_rd && i_addr == ADDR_TIMER_B_LOW)
            |=> o_rdata == $past(timer_b_reg[3:0], 2);
    endproperty
    a_latch: assert property (p_latch) else $error("low digit latch wrong");

    // further checks, each on a path that the bench drives
    property p_s_sub;
        @(posedge i_clock) disable iff (i_rst)
            i_subactive && !sub_rise |=> $stable(presc_s_reg);
    endproperty
    a_s_sub: assert property (p_s_sub) else $error("prescaler S ran without sub clock");
    property p_w_stop;
        @(posedge i_clock) disable iff (i_rst)
            i_stop_mode && !clr_watch |=> $stable(presc_w_reg);
    endproperty
    a_w_stop: assert property (p_w_stop) else $error("prescaler W ran in stop");
    property p_mode1_gap;
        @(posedge i_clock) disable iff (i_rst)
            wr_b1 && mode1_gap_reg != '0 |=> $stable(timer_b_mode_one_reg);
    endproperty
    a_mode1_gap: assert property (p_mode1_gap) else $error("early mode write taken");
    property p_low_hold;
        @(posedge i_clock) disable iff (i_rst) wr_low && !b_clk |=> $stable(timer_b_reg);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low digit write moved timer B");
    property p_out_zero;
        @(posedge i_clock) disable iff (i_rst)
            b_ovf && out_sel_reg == OUT_ZERO |=> !o_timer_output_pin;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("0 mode left output high");
    property p_out_one;
        @(posedge i_clock) disable iff (i_rst)
            b_ovf && out_sel_reg == OUT_ONE |=> o_timer_output_pin;
    endproperty
    a_out_one: assert property (p_out_one) else $error("1 mode left output low");
    property p_out_en;
        @(posedge i_clock) disable iff (i_rst)
            wr_osel |=> o_timer_output_en == ($past(i_wdata[1:0]) != OUT_NONE);
    endproperty
    a_out_en: assert property (p_out_en) else $error("output enable wrong");
    property p_flag_b_hold;
        @(posedge i_clock) disable iff (i_rst)
            o_timer_b_irq_flag && !(wr_flags && !i_wdata[FLAG_B_BIT]) |=> o_timer_b_irq_flag;
    endproperty
    a_flag_b_hold: assert property (p_flag_b_hold) else $error("timer B flag dropped");
    property p_rst_out;
        @(posedge i_clock) i_rst
            |=> !o_timer_output_pin && !o_timer_output_en && load_low_reg == DIGIT_ZERO;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("reset state wrong");
    property p_osel_read;
        @(posedge i_clock) disable iff (i_rst)
            i_rd && i_addr == ADDR_TIMER_B_OUTSEL |=> o_rdata == {2'h0, $past(out_sel_reg)};
    endproperty
    a_osel_read: assert property (p_osel_read) else $error("output select read wrong");
endmodule

// file: verilog/timer_ab_pkg.sv
package timer_ab_pkg;
    // register offsets (4-bit digit locations)
    localparam logic [9:0] ADDR_TIMER_A_MODE    = 10'h008;
    localparam logic [9:0] ADDR_TIMER_B_MODE1   = 10'h009;
    localparam logic [9:0] ADDR_TIMER_B_LOW     = 10'h00a;
    localparam logic [9:0] ADDR_TIMER_B_HIGH    = 10'h00b;
    localparam logic [9:0] ADDR_TIMER_B_OUTSEL  = 10'h013;
    localparam logic [9:0] ADDR_PORT_FUNC_C     = 10'h025;
    localparam logic [9:0] ADDR_IRQ_FLAGS       = 10'h030;  // chosen: flag digit
    localparam logic [9:0] ADDR_SOFT_CLEAR      = 10'h031;  // chosen: clear strobes
    // field positions
    localparam int TIME_BASE_BIT    = 3;
    localparam int RELOAD_BIT       = 3;   // timer_b_mode_one bit 3: reload
    localparam int FLAG_A_BIT       = 2;
    localparam int FLAG_B_BIT       = 0;
    localparam int EVENT_PIN_BIT    = 3;   // port_function_select_c bit 3
    localparam int CLR_WATCH_BIT    = 0;
    localparam int CLR_TIMER_A_BIT  = 1;
    // widths and values
    localparam int PRESC_S_W   = 11;
    localparam int PRESC_W_W   = 5;
    localparam int WDIV_W      = 3;
    localparam logic [7:0] COUNT_MAX  = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [1:0] OUT_NONE   = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_ZERO   = 2'h2;
    localparam logic [1:0] OUT_ONE    = 2'h3;
    localparam logic [2:0] EXT_EVENT_SEL = 3'h7;  // clock select code for event input
    localparam int MODE1_HOLDOFF = 2;             // cycles before a new mode1 write counts
endpackage
